//--- chg_cfg.svh
// Contract
// - System overvoltage sets a latched flag and disables the converter; flag zero after reset.
// - Latch clears by host writing zero after overvoltage ends, or by adapter unplug.
// - Latch-off and reverse boost faults latch high until the host reads status.
// - Throttle register shows seven trigger flags in bits 6 to 0.
// - Throttle register resets to zero; bits 15 to 7 always read zero.
// - Charge current spans 64 mA to 8128 mA in 64 mA steps.
// - Charge current register is zero after reset.
// - Input-good falling clears charge current unless input overvoltage caused it.
// - Battery-present falling clears charge current.
// - Overcurrent, thermal, latch-off and system overvoltage leave charge current unchanged.
// - Charge current field is bits 12 to 6, bit 6 worth 64 mA.
// - Writes setting bits 15 to 13 are invalid; bits 5 to 0 ignored.
`ifndef CHG_CFG_SVH
`define CHG_CFG_SVH
`define CHG_ADDR_CURRENT 8'h14
`define CHG_ADDR_STATUS 8'h20
`define CHG_ADDR_THROTTLE 8'h21
`define CHG_CUR_LSB 6
`define CHG_CUR_MSB 12
`define CHG_CUR_RSV_LSB 13
`define CHG_CUR_RESET 7'h00
`define CHG_ST_SYSTEM_OVERVOLTAGE 4
`define CHG_ST_LATCHOFF 2
`define CHG_ST_BOOST_OV 1
`define CHG_ST_BOOST_OC 0
`define CHG_TRIG_RESET 7'h00
`define CHG_STEP_MA 64
`endif

//--- chg_host.sv
`timescale 1ns/1ps
`default_nettype none
module chg_host (
	input wire logic clk,
	output logic [7:0] cmd_code,
	output logic wr_stb,
	output logic [15:0] wr_data,
	output logic rd_stb,
	input wire logic [15:0] rd_data_q,
	input wire logic rd_valid_q
);
	initial
	begin
		cmd_code = 8'h00;
		wr_stb = 1'b0;
		wr_data = 16'h0000;
		rd_stb = 1'b0;
	end
	// One whole word per write; stale data is inverted after
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(negedge clk);
		cmd_code = c;
		wr_data = d;
		wr_stb = 1'b1;
		@(negedge clk);
		wr_stb = 1'b0;
		wr_data = ~d;
	endtask
	// Command held until the answer shows
	task automatic rd(input logic [7:0] c, output logic [15:0] d);
		d = 16'hdead;
		@(negedge clk);
		cmd_code = c;
		rd_stb = 1'b1;
		@(negedge clk);
		rd_stb = 1'b0;
		for (int n = 0; n < 3; n++)
		begin
			if (rd_valid_q === 1'b1)
				d = rd_data_q;
			if (rd_valid_q === 1'b1)
				break;
			@(negedge clk);
		end
	endtask
endmodule
`default_nettype wire

//--- chg_pkg.sv
package chg_pkg;
	// Register selected by the SMBus command code
	typedef enum logic [1:0] {
		CHG_SEL_NONE = 2'b00,
		CHG_SEL_CURRENT = 2'b01,
		CHG_SEL_STATUS = 2'b10,
		CHG_SEL_THROTTLE = 2'b11
	} chg_sel_t;
endpackage

//--- chg_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "chg_cfg.svh"
module chg_regs #(
	parameter int CUR_W = 7
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] cmd_code,
	input wire logic wr_stb,
	input wire logic [15:0] wr_data,
	input wire logic rd_stb,
	output logic [15:0] rd_data_q,
	output logic rd_valid_q,
	input wire logic system_overvoltage,
	input wire logic adapter_present,
	input wire logic latchoff_fault,
	input wire logic reverse_boost_overvolt_fault,
	input wire logic reverse_boost_overcurrent_fault,
	input wire logic [6:0] processor_hot_triggers,
	input wire logic input_good,
	input wire logic input_overvoltage,
	input wire logic cell_count_battery_present,
	output logic converter_disable_q,
	output logic [CUR_W-1:0] charge_current_code_q
);
	logic sys_overvolt_flag_q;
	logic sys_overvolt_flag_d;
	logic [2:0] fault_q;
	logic [2:0] fault_d;
	logic [6:0] trig_q;
	logic [CUR_W-1:0] cur_d;
	logic good_prev_q;
	logic bat_prev_q;
	chg_pkg::chg_sel_t sel;
	wire logic [2:0] fault_in;
	wire logic wr_cur;
	wire logic wr_st;
	wire logic rd_st;
	wire logic wr_valid;
	wire logic ovp_clear;
	wire logic good_fall;
	wire logic bat_fall;
	wire logic cur_clear;
	wire logic [15:0] st_word;
	wire logic [15:0] trig_word;
	wire logic [15:0] cur_word;
	wire logic [15:0] rd_mux;

	// Command decode
	assign sel = (cmd_code == `CHG_ADDR_CURRENT) ? chg_pkg::CHG_SEL_CURRENT
		: (cmd_code == `CHG_ADDR_STATUS) ? chg_pkg::CHG_SEL_STATUS
		: (cmd_code == `CHG_ADDR_THROTTLE) ? chg_pkg::CHG_SEL_THROTTLE
		: chg_pkg::CHG_SEL_NONE;
	assign wr_cur = wr_stb && (sel == chg_pkg::CHG_SEL_CURRENT);
	assign wr_st = wr_stb && (sel == chg_pkg::CHG_SEL_STATUS);
	assign rd_st = rd_stb && (sel == chg_pkg::CHG_SEL_STATUS);
	// Any reserved upper bit set voids the whole charge current write; status writes ignore it
	assign wr_valid = (wr_data[15:`CHG_CUR_RSV_LSB] == 3'h0);

	// Overvoltage latch: only a zero write after the event is gone, or unplug, clears it
	assign ovp_clear = (wr_st && !wr_data[`CHG_ST_SYSTEM_OVERVOLTAGE] && !system_overvoltage)
		|| !adapter_present;
	always_comb
	begin
		sys_overvolt_flag_d = sys_overvolt_flag_q;
		if (ovp_clear)
			sys_overvolt_flag_d = 1'b0;
		if (system_overvoltage)
			sys_overvolt_flag_d = 1'b1; // Set beats clear
	end

	// Read-cleared faults; a fault in the read cycle survives so no event is lost
	assign fault_in = {latchoff_fault, reverse_boost_overvolt_fault, reverse_boost_overcurrent_fault};
	generate
		for (genvar i = 0; i < 3; i++)
		begin : g_fault
			assign fault_d[i] = (fault_q[i] && !rd_st) || fault_in[i];
		end
	endgenerate

	// Setpoint clears on input-good loss without input overvoltage, or on battery loss, not on other faults
	assign good_fall = good_prev_q && !input_good;
	assign bat_fall = bat_prev_q && !cell_count_battery_present;
	assign cur_clear = (good_fall && !input_overvoltage) || bat_fall;
	always_comb
	begin
		cur_d = charge_current_code_q;
		if (wr_cur && wr_valid)
			cur_d = wr_data[`CHG_CUR_MSB:`CHG_CUR_LSB];
		if (cur_clear)
			cur_d = `CHG_CUR_RESET; // Removal outranks a racing write
	end

	// Read words; reserved and unmodelled bits are zero
	assign st_word = {11'h000, sys_overvolt_flag_q, 1'b0, fault_q};
	assign trig_word = {9'h000, trig_q};
	assign cur_word = {3'h0, charge_current_code_q, 6'h00};
	assign rd_mux = (sel == chg_pkg::CHG_SEL_CURRENT) ? cur_word
		: (sel == chg_pkg::CHG_SEL_STATUS) ? st_word
		: (sel == chg_pkg::CHG_SEL_THROTTLE) ? trig_word
		: 16'h0000;

	// Status and trigger state
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sys_overvolt_flag_q <= 1'b0;
			fault_q <= 3'h0;
			trig_q <= `CHG_TRIG_RESET;
			converter_disable_q <= 1'b0;
		end
		else
		begin
			sys_overvolt_flag_q <= sys_overvolt_flag_d;
			fault_q <= fault_d;
			trig_q <= processor_hot_triggers;
			converter_disable_q <= sys_overvolt_flag_d;
		end
	end

	// Setpoint and edge history; history resets to 0 so power-up is no falling edge
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			charge_current_code_q <= `CHG_CUR_RESET;
			good_prev_q <= 1'b0;
			bat_prev_q <= 1'b0;
		end
		else
		begin
			charge_current_code_q <= cur_d;
			good_prev_q <= input_good;
			bat_prev_q <= cell_count_battery_present;
		end
	end

	// Read answer one cycle after the strobe
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			rd_data_q <= 16'h0000;
			rd_valid_q <= 1'b0;
		end
		else
		begin
			rd_valid_q <= rd_stb;
			if (rd_stb)
				rd_data_q <= rd_mux;
		end
	end

	// Overvoltage steps, used only by a_ovp_sets_disable below
	sequence s_ovp_event;
		system_overvoltage;
	endsequence
	sequence s_ovp_held;
		sys_overvolt_flag_q && converter_disable_q;
	endsequence

	a_ovp_sets_disable: assert property (@(posedge clk) disable iff (rst)
		s_ovp_event |=> s_ovp_held)
		else $error("overvoltage did not latch and disable");
	a_ovp_no_early_clear: assert property (@(posedge clk) disable iff (rst)
		$fell(sys_overvolt_flag_q) |-> $past(!system_overvoltage && (wr_st || !adapter_present)))
		else $error("overvoltage latch cleared without cause");
	a_fault_holds: assert property (@(posedge clk) disable iff (rst)
		$fell(fault_q[0]) |-> $past(rd_st) && $past(!reverse_boost_overcurrent_fault))
		else $error("fault cleared without status read");
	a_fault_latches: assert property (@(posedge clk) disable iff (rst)
		latchoff_fault |=> fault_q[2])
		else $error("latch-off fault not latched");
	a_trig_follows: assert property (@(posedge clk) disable iff (rst)
		rd_stb && (cmd_code == `CHG_ADDR_THROTTLE) |=> rd_valid_q && (rd_data_q == {9'h000, $past(trig_q)}))
		else $error("trigger read mismatch");
	a_cur_write: assert property (@(posedge clk) disable iff (rst)
		wr_cur && wr_valid && !cur_clear |=> charge_current_code_q == $past(wr_data[12:6]))
		else $error("setpoint write lost");
	a_cur_invalid: assert property (@(posedge clk) disable iff (rst)
		wr_cur && !wr_valid && !cur_clear |=> $stable(charge_current_code_q))
		else $error("invalid write changed setpoint");
	a_cur_removal: assert property (@(posedge clk) disable iff (rst)
		bat_fall |=> charge_current_code_q == 7'h00)
		else $error("battery removal did not clear setpoint");
	a_cur_input_overvoltage_keep: assert property (@(posedge clk) disable iff (rst)
		good_fall && input_overvoltage && !bat_fall && !wr_cur |=> $stable(charge_current_code_q))
		else $error("input overvoltage cleared setpoint");
	a_status_rsv: assert property (@(posedge clk) disable iff (rst)
		rd_valid_q && ($past(sel) == chg_pkg::CHG_SEL_STATUS) |-> (rd_data_q[15:5] == 11'h000) && !rd_data_q[3])
		else $error("reserved status bits nonzero");

	// Clear request: event gone, and a zero written to the latch bit or adapter unplugged
	sequence s_ovp_clear_req;
		!system_overvoltage && ((wr_st && !wr_data[`CHG_ST_SYSTEM_OVERVOLTAGE]) || !adapter_present);
	endsequence
	a_ovp_clears: assert property (@(posedge clk) disable iff (rst)
		s_ovp_clear_req |=> !sys_overvolt_flag_q && !converter_disable_q)
		else $error("overvoltage latch not cleared on request");

	// Faults: every source latches, a read with no event pending empties the word
	a_fault_all_latch: assert property (@(posedge clk) disable iff (rst)
		(fault_in != 3'h0) |=> ((fault_q & $past(fault_in)) == $past(fault_in)))
		else $error("fault source not latched");
	a_fault_read_clear: assert property (@(posedge clk) disable iff (rst)
		rd_st && (fault_in == 3'h0) |=> (fault_q == 3'h0))
		else $error("status read did not clear faults");

	// Setpoint moves only on a valid write or a removal clear
	a_cur_good_fall: assert property (@(posedge clk) disable iff (rst)
		good_fall && !input_overvoltage |=> (charge_current_code_q == '0))
		else $error("input-good loss did not clear setpoint");
	a_cur_keeps: assert property (@(posedge clk) disable iff (rst)
		!wr_cur && !cur_clear |=> $stable(charge_current_code_q))
		else $error("setpoint moved without write or clear");

	// Throttle word upper byte and bit 7 never show anything
	a_throttle_rsv: assert property (@(posedge clk) disable iff (rst)
		rd_valid_q && ($past(sel) == chg_pkg::CHG_SEL_THROTTLE) |-> (rd_data_q[15:7] == 9'h000))
		else $error("reserved throttle bits nonzero");
endmodule
`default_nettype wire

//--- chg_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module chg_regs_tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] cmd;
	logic ws, rs, rv, sov = 1'b0, ap = 1'b1, ig = 1'b1, iov = 1'b0, bp = 1'b1, cdis;
	logic [15:0] wd, rdq, r, v;
	logic [2:0] flt = 3'h0;
	logic [6:0] trg = 7'h00, code, ec = 7'h00;
	int mismatches = 0, check_count = 0, cyc = 0;
	always #50 clk = ~clk;
	chg_host host (.clk(clk), .cmd_code(cmd), .wr_stb(ws), .wr_data(wd), .rd_stb(rs),
		.rd_data_q(rdq), .rd_valid_q(rv));
	chg_regs dut (.clk(clk), .rst(rst), .cmd_code(cmd), .wr_stb(ws), .wr_data(wd), .rd_stb(rs),
		.rd_data_q(rdq), .rd_valid_q(rv), .system_overvoltage(sov), .adapter_present(ap),
		.latchoff_fault(flt[2]), .reverse_boost_overvolt_fault(flt[1]),
		.reverse_boost_overcurrent_fault(flt[0]), .processor_hot_triggers(trg), .input_good(ig),
		.input_overvoltage(iov), .cell_count_battery_present(bp), .converter_disable_q(cdis),
		.charge_current_code_q(code));
	task automatic end_sim();
		if (mismatches == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e)
		begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// Invalid upper bits leave the old setpoint
	function automatic logic [6:0] nxt(input logic [6:0] o, input logic [15:0] d);
		return (d[15:13] != 3'h0) ? o : d[12:6];
	endfunction
	// Hang guard, tests need far fewer cycles
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			mismatches++;
			end_sim();
		end
	end
	initial
	begin
		void'($urandom(32'hdb41));
		repeat (5) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		host.rd(8'h14, r); chk(r, 16'h0000);
		host.rd(8'h20, r); chk(r, 16'h0000);
		host.rd(8'h21, r); chk(r, 16'h0000);
		host.rd(8'h55, r); chk(r, 16'h0000);
		for (int i = 0; i < 12; i++)
		begin
			v = (i == 0) ? 16'h1fff : 16'($urandom);
			if (i % 2 == 1) v[15:13] = 3'h0;
			host.wr(8'h14, v);
			ec = nxt(ec, v);
			host.rd(8'h14, r); chk(r, {3'h0, ec, 6'h00});
			chk({9'h0, code}, {9'h0, ec});
		end
		host.wr(8'h14, 16'h0fc0);
		host.wr(8'h55, 16'h1000);
		chk({9'h0, code}, 16'h003f);
		for (int i = 0; i < 4; i++)
		begin
			@(negedge clk) trg = 7'($urandom);
			host.rd(8'h21, r); chk(r, {9'h0, trg});
		end
		@(negedge clk) {sov, flt[2]} = 2'b11;
		@(negedge clk) chk({15'h0, cdis}, 16'h0001);
		host.wr(8'h20, 16'h0000);
		@(negedge clk) {sov, flt[2]} = 2'b00;
		chk({15'h0, cdis}, 16'h0001);
		host.rd(8'h20, r); chk(r, 16'h0014);
		chk({9'h0, code}, 16'h003f);
		host.wr(8'h20, 16'hffef);
		host.rd(8'h20, r); chk(r, 16'h0000);
		@(negedge clk) sov = 1'b1;
		@(negedge clk) {sov, ap} = 2'b00;
		@(negedge clk) ap = 1'b1;
		@(negedge clk) chk({15'h0, cdis}, 16'h0000);
		for (int k = 0; k < 2; k++)
		begin
			@(negedge clk) flt = 3'b001 << k;
			@(negedge clk) flt = 3'h0;
			host.rd(8'h20, r); chk(r, 16'h0001 << k);
			host.rd(8'h20, r); chk(r, 16'h0000);
		end
		@(negedge clk) {iov, ig} = 2'b10;
		repeat (2) @(negedge clk);
		chk({9'h0, code}, 16'h003f);
		{iov, ig} = 2'b01;
		@(negedge clk) ig = 1'b0;
		repeat (2) @(negedge clk);
		chk({9'h0, code}, 16'h0000);
		ig = 1'b1;
		host.wr(8'h14, 16'h0040);
		chk({9'h0, code}, 16'h0001);
		@(negedge clk) bp = 1'b0;
		repeat (2) @(negedge clk);
		chk({9'h0, code}, 16'h0000);
		end_sim();
	end
endmodule
`default_nettype wire
